//--- src/sfbcp_port.v
// Serial boot port: programmer link and command interpreter.
`timescale 1ns/1ns
//
// Behaviour
// - Enter programming mode if high voltage at release.
// - Sample received bits on transfer clock rise.
// - Change transmitted bits on transfer clock fall.
// - Frames are eight bits, least significant first.
// - Handshake low when ready, high at start.
// - Handshake high while transferring, programming or erasing.
// - Only user area may be rewritten.
// - Seven-byte identity gates commands on nonblank flash.
// - Unverified: only status, identity, version accepted.
// - Blank flash accepts every command.
// - First byte selects command by code.
// - Page read returns 256 bytes, bytes four-259.
// - Erase all starts only after confirmation byte.
// - Status returns primary then secondary status byte.
// - Version sends bytes two through nine.
// - Boot output returns 256-byte boot page.
// - Only defined output bytes flow to programmer.
// - Missing boot control program disables the mode.
// - Status bits: ready, erase error, program error.
// - Status reads 80 hex after reset.
// - Clear status clears errors, handshake falls.
// - Lock read always returns unlocked.
module sfbcp_port #(
    parameter [63:0] VERSION_INFO = 64'h3130302e3156_2020 // Arbitrary value.
)(
    input wire ref_clk,
    input wire rst,
    input wire mode_select_pin,
    input wire boot_area_intact,
    input wire transfer_clock_pin,
    input wire serial_in_pin,
    output reg serial_out_pin,
    output reg handshake_out_port,
    output reg prog_mode_active,
    output reg id_verified,
    output reg [7:0] status_byte,
    output reg [23:0] flash_addr,
    output reg flash_boot_sel,
    output reg flash_rd_req,
    output reg flash_wr_req,
    output reg [7:0] flash_wr_data,
    output reg flash_erase_req,
    input wire flash_ack,
    input wire flash_fail,
    input wire [7:0] flash_rd_data,
    input wire flash_blank,
    input wire [55:0] id_code,
    output reg [7:0] dl_data,
    output reg dl_strobe,
    output reg dl_done,
    output reg dl_ok
);
`include "sfbcp_map.vh"

    localparam [5:0] ST_BOOT = 6'h01;
    localparam [5:0] ST_OFF = 6'h02;
    localparam [5:0] ST_LINK = 6'h04;
    localparam [5:0] ST_READ = 6'h08;
    localparam [5:0] ST_WRITE = 6'h10;
    localparam [5:0] ST_ERASE = 6'h20;

    reg mode_s1_reg, mode_s2_reg, sclk_s1_reg, sclk_s2_reg, sclk_d_reg, rx_s1_reg, rx_s2_reg;
    reg [5:0] state_reg;
    reg [2:0] bit_cnt_reg;
    reg [7:0] rx_sh_reg, tx_sh_reg, cmd_reg, id_size_reg, dl_sum_reg, dl_ck_reg;
    reg [8:0] pos_reg;
    reg [15:0] page_reg, dl_size_reg;
    reg id_match_reg, eerr_reg, perr_reg, ready_reg;
    wire sclk_rise;
    wire sclk_fall;
    wire [7:0] rx_byte;
    wire [7:0] off_rd;
    wire [7:0] off_wr;
    wire [7:0] id_idx;
    wire known_cmd;
    wire open_cmd;

    // Two flops on each programmer pin; logic reads the second only.
    always @(posedge ref_clk)
    begin
        mode_s1_reg <= mode_select_pin;
        mode_s2_reg <= mode_s1_reg;
        sclk_s1_reg <= transfer_clock_pin;
        sclk_s2_reg <= sclk_s1_reg;
        rx_s1_reg <= serial_in_pin;
        rx_s2_reg <= rx_s1_reg;
    end

    // Edges of the synced transfer clock, which idles high.
    assign sclk_rise = sclk_s2_reg & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s2_reg & sclk_d_reg;
    assign rx_byte = {rx_s2_reg, rx_sh_reg[7:1]};
    assign off_rd = pos_reg[7:0] - 8'h02;
    assign off_wr = pos_reg[7:0] - 8'h03;
    assign id_idx = pos_reg[7:0] - 8'h05;

    // Command decode and the identity gate.
    assign known_cmd = open_cmd || (rx_byte == `SFBCP_CMD_PAGE_READ)
        || (rx_byte == `SFBCP_CMD_PAGE_PROG) || (rx_byte == `SFBCP_CMD_ERASE_ALL)
        || (rx_byte == `SFBCP_CMD_CLR_STAT) || (rx_byte == `SFBCP_CMD_LOCK_READ)
        || (rx_byte == `SFBCP_CMD_DOWNLOAD) || (rx_byte == `SFBCP_CMD_BOOT_OUT);
    assign open_cmd = (rx_byte == `SFBCP_CMD_READ_STAT) || (rx_byte == `SFBCP_CMD_ID_CHECK)
        || (rx_byte == `SFBCP_CMD_VERSION);

    // Main sequencer; flash work holds the handshake high so bytes never race it.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg <= ST_BOOT;
            sclk_d_reg <= 1'b1;
            bit_cnt_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
            tx_sh_reg <= 8'hff;
            cmd_reg <= 8'h00;
            pos_reg <= 9'h000;
            page_reg <= 16'h0000;
            id_size_reg <= 8'h00;
            id_match_reg <= 1'b0;
            dl_size_reg <= 16'h0000;
            dl_sum_reg <= 8'h00;
            dl_ck_reg <= 8'h00;
            eerr_reg <= 1'b0;
            perr_reg <= 1'b0;
            ready_reg <= 1'b1;
            status_byte <= `SFBCP_STATUS_RESET;
            serial_out_pin <= 1'b1;
            handshake_out_port <= 1'b1;
            prog_mode_active <= 1'b0;
            id_verified <= 1'b0;
            flash_addr <= 24'h000000;
            flash_boot_sel <= 1'b0;
            flash_rd_req <= 1'b0;
            flash_wr_req <= 1'b0;
            flash_wr_data <= 8'h00;
            flash_erase_req <= 1'b0;
            dl_data <= 8'h00;
            dl_strobe <= 1'b0;
            dl_done <= 1'b0;
            dl_ok <= 1'b0;
        end
        else
        begin
            sclk_d_reg <= sclk_s2_reg;
            dl_strobe <= 1'b0;
            dl_done <= 1'b0;
            status_byte <= {ready_reg, 1'b0, eerr_reg, perr_reg, 4'h0};
            case (state_reg)
                ST_BOOT:
                begin
                    // Mode pin is caught at the first edge after release.
                    if (mode_s2_reg && boot_area_intact)
                    begin
                        state_reg <= ST_LINK;
                        prog_mode_active <= 1'b1;
                        handshake_out_port <= 1'b0;
                    end
                    else
                        state_reg <= ST_OFF;
                end
                ST_OFF:
                begin
                    // Normal processor mode: the port stays silent.
                    handshake_out_port <= 1'b1;
                end
                ST_LINK:
                begin
                    if (sclk_fall)
                    begin
                        serial_out_pin <= tx_sh_reg[0];
                        tx_sh_reg <= {1'b1, tx_sh_reg[7:1]};
                        handshake_out_port <= 1'b1;
                    end
                    if (sclk_rise)
                    begin
                        handshake_out_port <= 1'b1;
                        rx_sh_reg <= rx_byte;
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == `SFBCP_FRAME_BITS)
                        begin
                            // A whole byte is in; outgoing filler is all ones.
                            handshake_out_port <= 1'b0;
                            tx_sh_reg <= 8'hff;
                            pos_reg <= pos_reg + 9'h001;
                            if (pos_reg == 9'h000)
                            begin
                                if (!known_cmd || !(open_cmd || id_verified || flash_blank))
                                    pos_reg <= 9'h000;
                                cmd_reg <= rx_byte;
                                if (rx_byte == `SFBCP_CMD_READ_STAT)
                                    tx_sh_reg <= status_byte;
                                if (rx_byte == `SFBCP_CMD_VERSION)
                                    tx_sh_reg <= VERSION_INFO[7:0];
                                if (rx_byte == `SFBCP_CMD_CLR_STAT
                                    && (id_verified || flash_blank))
                                begin
                                    eerr_reg <= 1'b0;
                                    perr_reg <= 1'b0;
                                    pos_reg <= 9'h000;
                                end
                            end
                            else
                            begin
                                case (cmd_reg)
                                    `SFBCP_CMD_PAGE_READ, `SFBCP_CMD_BOOT_OUT,
                                    `SFBCP_CMD_LOCK_READ, `SFBCP_CMD_PAGE_PROG:
                                    begin
                                        if (pos_reg == 9'h001)
                                            page_reg[7:0] <= rx_byte;
                                        else if (pos_reg == `SFBCP_POS_ADDR_HI)
                                            page_reg[15:8] <= rx_byte;
                                        if (cmd_reg == `SFBCP_CMD_LOCK_READ)
                                        begin
                                            if (pos_reg == `SFBCP_POS_ADDR_HI)
                                                tx_sh_reg <= `SFBCP_LOCK_UNLOCKED;
                                            else if (pos_reg > `SFBCP_POS_ADDR_HI)
                                                pos_reg <= 9'h000;
                                        end
                                        else if (cmd_reg == `SFBCP_CMD_PAGE_PROG)
                                        begin
                                            if (pos_reg > `SFBCP_POS_ADDR_HI)
                                            begin
                                                // Writes only reach the user space.
                                                flash_addr <= {page_reg, off_wr};
                                                flash_boot_sel <= 1'b0;
                                                flash_wr_data <= rx_byte;
                                                flash_wr_req <= 1'b1;
                                                ready_reg <= 1'b0;
                                                handshake_out_port <= 1'b1;
                                                state_reg <= ST_WRITE;
                                                if (pos_reg == `SFBCP_POS_PAGE_LAST)
                                                    pos_reg <= 9'h000;
                                            end
                                        end
                                        else if (pos_reg >= `SFBCP_POS_ADDR_HI)
                                        begin
                                            if (pos_reg == `SFBCP_POS_PAGE_LAST)
                                                pos_reg <= 9'h000;
                                            else
                                            begin
                                                flash_addr <= {pos_reg == `SFBCP_POS_ADDR_HI
                                                    ? rx_byte : page_reg[15:8],
                                                    page_reg[7:0], off_rd};
                                                flash_boot_sel <= (cmd_reg
                                                    == `SFBCP_CMD_BOOT_OUT);
                                                flash_rd_req <= 1'b1;
                                                handshake_out_port <= 1'b1;
                                                state_reg <= ST_READ;
                                            end
                                        end
                                    end
                                    `SFBCP_CMD_ERASE_ALL:
                                    begin
                                        pos_reg <= 9'h000;
                                        if (rx_byte == `SFBCP_ERASE_CONFIRM)
                                        begin
                                            flash_erase_req <= 1'b1;
                                            ready_reg <= 1'b0;
                                            handshake_out_port <= 1'b1;
                                            state_reg <= ST_ERASE;
                                        end
                                    end
                                    `SFBCP_CMD_READ_STAT:
                                    begin
                                        if (pos_reg == 9'h001)
                                            tx_sh_reg <= `SFBCP_STATUS_EXT_RESET;
                                        else
                                            pos_reg <= 9'h000;
                                    end
                                    `SFBCP_CMD_VERSION:
                                    begin
                                        if (pos_reg == `SFBCP_POS_VER_LAST)
                                            pos_reg <= 9'h000;
                                        else
                                            tx_sh_reg <= VERSION_INFO[pos_reg[2:0] * 8 +: 8];
                                    end
                                    `SFBCP_CMD_ID_CHECK:
                                    begin
                                        // Address bytes are taken and ignored.
                                        if (pos_reg == `SFBCP_POS_ID_SIZE)
                                        begin
                                            id_size_reg <= rx_byte;
                                            id_match_reg <= (rx_byte == `SFBCP_ID_BYTES);
                                            if (rx_byte == 8'h00)
                                            begin
                                                id_verified <= 1'b0;
                                                pos_reg <= 9'h000;
                                            end
                                        end
                                        else if (pos_reg > `SFBCP_POS_ID_SIZE)
                                        begin
                                            if (id_idx < `SFBCP_ID_BYTES
                                                && rx_byte != id_code[id_idx[2:0] * 8 +: 8])
                                                id_match_reg <= 1'b0;
                                            if (id_idx + 8'h01 == id_size_reg)
                                            begin
                                                // All seven bytes must agree.
                                                id_verified <= id_match_reg && (id_idx
                                                    >= `SFBCP_ID_BYTES || rx_byte
                                                    == id_code[id_idx[2:0] * 8 +: 8]);
                                                pos_reg <= 9'h000;
                                            end
                                        end
                                    end
                                    `SFBCP_CMD_DOWNLOAD:
                                    begin
                                        if (pos_reg == 9'h001)
                                            dl_size_reg[7:0] <= rx_byte;
                                        else if (pos_reg == `SFBCP_POS_ADDR_HI)
                                            dl_size_reg[15:8] <= rx_byte;
                                        else if (pos_reg == `SFBCP_POS_DL_SUM)
                                        begin
                                            dl_ck_reg <= rx_byte;
                                            dl_sum_reg <= 8'h00;
                                            if (dl_size_reg == 16'h0000)
                                                pos_reg <= 9'h000;
                                        end
                                        else
                                        begin
                                            // The checksum is the byte sum of the image.
                                            dl_data <= rx_byte;
                                            dl_strobe <= 1'b1;
                                            dl_sum_reg <= dl_sum_reg + rx_byte;
                                            dl_size_reg <= dl_size_reg - 16'h0001;
                                            pos_reg <= `SFBCP_POS_DL_SUM + 9'h001;
                                            if (dl_size_reg == 16'h0001)
                                            begin
                                                dl_done <= 1'b1;
                                                dl_ok <= (dl_sum_reg + rx_byte == dl_ck_reg);
                                                pos_reg <= 9'h000;
                                            end
                                        end
                                    end
                                    default:
                                        pos_reg <= 9'h000;
                                endcase
                            end
                        end
                    end
                end
                ST_READ:
                begin
                    if (flash_ack)
                    begin
                        flash_rd_req <= 1'b0;
                        tx_sh_reg <= flash_rd_data;
                        handshake_out_port <= 1'b0;
                        state_reg <= ST_LINK;
                    end
                end
                ST_WRITE, ST_ERASE:
                begin
                    if (flash_ack)
                    begin
                        flash_wr_req <= 1'b0;
                        flash_erase_req <= 1'b0;
                        ready_reg <= 1'b1;
                        if (flash_fail && state_reg == ST_WRITE)
                            perr_reg <= 1'b1;
                        if (flash_fail && state_reg == ST_ERASE)
                            eerr_reg <= 1'b1;
                        handshake_out_port <= 1'b0;
                        state_reg <= ST_LINK;
                    end
                end
                default:
                    state_reg <= ST_BOOT;
            endcase
        end
    end

endmodule

//--- src/sfbcp_map.vh
// Command codes, status layout and frame positions of the boot port.
`ifndef SFBCP_MAP_VH
`define SFBCP_MAP_VH

`define SFBCP_CMD_PAGE_READ 8'hff
`define SFBCP_CMD_PAGE_PROG 8'h41
`define SFBCP_CMD_ERASE_ALL 8'ha7
`define SFBCP_CMD_READ_STAT 8'h70
`define SFBCP_CMD_CLR_STAT 8'h50
`define SFBCP_CMD_LOCK_READ 8'h71
`define SFBCP_CMD_ID_CHECK 8'hf5
`define SFBCP_CMD_DOWNLOAD 8'hfa
`define SFBCP_CMD_VERSION 8'hfb
`define SFBCP_CMD_BOOT_OUT 8'hfc
`define SFBCP_ERASE_CONFIRM 8'hd0

`define SFBCP_READY_BIT 7
`define SFBCP_ERASE_ERR_BIT 5
`define SFBCP_PROG_ERR_BIT 4
`define SFBCP_STATUS_RESET 8'h80
`define SFBCP_STATUS_EXT_RESET 8'h00
`define SFBCP_LOCK_UNLOCKED 8'h01

`define SFBCP_FRAME_BITS 3'h7
`define SFBCP_POS_ADDR_HI 9'h002
`define SFBCP_POS_PAGE_LAST 9'h102
`define SFBCP_POS_VER_LAST 9'h008
`define SFBCP_POS_ID_SIZE 9'h004
`define SFBCP_POS_DL_SUM 9'h003
`define SFBCP_ID_BYTES 8'h07
`define SFBCP_RESET_OSC_CYCLES 20

`endif

//--- bench/sfbcp_port_asserts.sv
// Pin-level checks on the boot port.
`timescale 1ns/1ns
module sfbcp_port_asserts (
    input wire ref_clk,
    input wire rst,
    input wire transfer_clock_pin,
    input wire handshake_out_port,
    input wire prog_mode_active,
    input wire [7:0] status_byte,
    input wire flash_boot_sel,
    input wire flash_rd_req,
    input wire flash_wr_req,
    input wire flash_erase_req,
    input wire flash_ack,
    input wire flash_fail
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // A flash job ends at its acknowledge.
    sequence s_flash_done;
        (flash_rd_req || flash_wr_req || flash_erase_req) && flash_ack;
    endsequence
    // A byte starts with a clock fall while idle.
    sequence s_byte_start;
        $fell(transfer_clock_pin) && !handshake_out_port;
    endsequence
    AST_RESET_STATUS: assert property ($fell(rst) |-> status_byte == 8'h80)
        else $error("status byte wrong after reset");
    AST_MODE_HS: assert property (!prog_mode_active |-> handshake_out_port)
        else $error("busy low outside programming mode");
    AST_HS_RISE: assert property (s_byte_start |-> ##[1:5] handshake_out_port)
        else $error("busy did not rise at byte start");
    AST_ACK_DONE: assert property (s_flash_done |-> ##[1:2] !handshake_out_port)
        else $error("busy did not fall after flash job");
    AST_BUSY_REQ: assert property ((flash_rd_req || flash_wr_req || flash_erase_req)
        |-> handshake_out_port)
        else $error("busy low during flash job");
    AST_WR_USER: assert property (flash_wr_req |-> !flash_boot_sel)
        else $error("write aimed at boot area");
    AST_ERASE_BUSY: assert property ($rose(flash_erase_req) |-> ##[1:2] !status_byte[7])
        else $error("ready bit set during erase");
    AST_ERASE_FAIL: assert property (flash_erase_req && flash_ack && flash_fail
        |-> ##[1:3] status_byte[5])
        else $error("erase error flag not set");
endmodule
bind sfbcp_port sfbcp_port_asserts sfbcp_port_asserts_inst (.ref_clk(ref_clk), .rst(rst),
    .transfer_clock_pin(transfer_clock_pin), .handshake_out_port(handshake_out_port),
    .prog_mode_active(prog_mode_active), .status_byte(status_byte),
    .flash_boot_sel(flash_boot_sel), .flash_rd_req(flash_rd_req), .flash_wr_req(flash_wr_req),
    .flash_erase_req(flash_erase_req), .flash_ack(flash_ack), .flash_fail(flash_fail));

//--- bench/sfbcp_prog_model.sv
// Serial programmer model driving the transfer clock.
`timescale 1ns/1ns
module sfbcp_prog_model (
    input wire ref_clk,
    input wire handshake_out_port,
    input wire serial_out_pin,
    output reg transfer_clock_pin,
    output reg serial_in_pin,
    output reg hang
);
    initial
    begin
        transfer_clock_pin = 1'b1;
        serial_in_pin = 1'b1;
        hang = 1'b0;
    end
    // One byte each way; the clock idles high between frames.
    task xfer(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            i = 0;
            while (handshake_out_port !== 1'b0 && i < 20000)
            begin
                @(posedge ref_clk);
                i = i + 1;
            end
            hang = (i == 20000);
            #3;
            for (i = 0; i < 8; i = i + 1)
            begin
                transfer_clock_pin = 1'b0;
                serial_in_pin = tx[i];
                #80;
                transfer_clock_pin = 1'b1;
                rx[i] = serial_out_pin;
                #80;
            end
            // Spoil data so a late sample fails.
            serial_in_pin = ~serial_in_pin;
        end
    endtask
endmodule

//--- bench/sfbcp_port_bench.sv
// Self-checking bench for the boot port.
`timescale 1ns/1ns
module sfbcp_port_bench;
    localparam [63:0] VINFO = 64'h0123456789abcdef; // Arbitrary value.
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg mode_select_pin = 1'b1;
    reg boot_area_intact = 1'b1;
    reg flash_blank = 1'b0;
    reg flash_ack = 1'b0;
    reg flash_fail = 1'b0;
    reg [7:0] flash_rd_data = 8'h00;
    reg [55:0] id_code = 56'h0;
    wire tclk, sin, sout, hs, pma, idv, bsel, rd_req, wr_req, er_req, dl_ok, hang;
    wire [7:0] stat, wr_data;
    wire [23:0] addr;
    integer seed = 43;
    integer num_errors = 0;
    integer check_count = 0;
    integer cyc = 0;
    integer k;
    reg [7:0] rx, am, ah, d0, d1;
    reg [63:0] idr;
    reg [7:0] exp_q[$];
    reg [7:0] wr_q[$];
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    sfbcp_port #(.VERSION_INFO(VINFO)) sfbcp_port_inst (.ref_clk(ref_clk), .rst(rst),
        .mode_select_pin(mode_select_pin), .boot_area_intact(boot_area_intact),
        .transfer_clock_pin(tclk), .serial_in_pin(sin), .serial_out_pin(sout),
        .handshake_out_port(hs), .prog_mode_active(pma), .id_verified(idv),
        .status_byte(stat), .flash_addr(addr), .flash_boot_sel(bsel), .flash_rd_req(rd_req),
        .flash_wr_req(wr_req), .flash_wr_data(wr_data), .flash_erase_req(er_req),
        .flash_ack(flash_ack), .flash_fail(flash_fail), .flash_rd_data(flash_rd_data),
        .flash_blank(flash_blank), .id_code(id_code), .dl_data(), .dl_strobe(),
        .dl_done(), .dl_ok(dl_ok));
    sfbcp_prog_model sfbcp_prog_model_inst (.ref_clk(ref_clk), .handshake_out_port(hs),
        .serial_out_pin(sout), .transfer_clock_pin(tclk), .serial_in_pin(sin), .hang(hang));
    // Flash stand-in: random ack delay, data mixes the address bytes.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        flash_ack <= 1'b0;
        if ((rd_req | wr_req | er_req) && !flash_ack && ($random(seed) & 3) == 0)
        begin
            flash_ack <= 1'b1;
            flash_rd_data <= addr[7:0] ^ addr[15:8] ^ addr[23:16];
            if (wr_req)
                wr_q.push_back(wr_data ^ addr[7:0] ^ addr[15:8] ^ addr[23:16]);
        end
        if (cyc == 90000 || hang)
        begin
            num_errors = num_errors + 1;
            stop_test;
        end
    end
    task chk(input string what, input [7:0] exp, input [7:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("[ERR] %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task send(input [7:0] b);
        sfbcp_prog_model_inst.xfer(b, rx);
    endtask
    task rd_stat(input [7:0] exp);
        begin
            send(8'h70);
            send(8'hff);
            chk("status", exp, rx);
            send(8'hff);
            chk("status ext", 8'h00, rx);
        end
    endtask
    task rst_dut(input m, input intact, input blank);
        begin
            @(posedge ref_clk);
            rst <= 1'b1;
            mode_select_pin <= m;
            boot_area_intact <= intact;
            flash_blank <= blank;
            repeat (20) @(posedge ref_clk);
            rst <= 1'b0;
        end
    endtask
    task id_chk(input [55:0] code, input [7:0] exp);
        integer j;
        begin
            send(8'hf5);
            for (j = 0; j < 3; j = j + 1)
                send(8'h00);
            send(8'h07);
            for (j = 0; j < 7; j = j + 1)
                send(code[8 * j +: 8]);
            rd_stat(8'h80);
            chk("id_verified", exp, {7'h0, idv});
        end
    endtask
    // Gating, every command, resets and modes.
    initial
    begin
        rst_dut(1'b1, 1'b1, 1'b0);
        rd_stat(8'h80);
        send(8'h33);
        send(8'hff);
        rd_stat(8'h80);
        send(8'hfb);
        for (k = 0; k < 8; k = k + 1)
        begin
            send(8'hff);
            chk("version", VINFO[8 * k +: 8], rx);
        end
        $display("gating and version done");
        idr = {$random(seed), $random(seed)};
        id_code <= idr[55:0];
        id_chk(idr[55:0] ^ 56'h01_0000_0000_0000, 8'h00);
        id_chk(idr[55:0], 8'h01);
        am = $random(seed);
        ah = $random(seed);
        send(8'hff);
        send(am);
        send(ah);
        for (k = 0; k < 256; k = k + 1)
            exp_q.push_back(k[7:0] ^ am ^ ah);
        while (exp_q.size() > 0)
        begin
            send(8'hff);
            chk("page read", exp_q.pop_front(), rx);
        end
        send(8'h71);
        send(am);
        send(ah);
        send(8'hff);
        chk("lock bit", 8'h01, rx);
        $display("id and reads done");
        flash_fail <= 1'b1;
        send(8'ha7);
        send(8'hd0);
        rd_stat(8'ha0);
        flash_fail <= 1'b0;
        send(8'h50);
        rd_stat(8'h80);
        send(8'h41);
        send(am);
        send(ah);
        for (k = 0; k < 3; k = k + 1)
            send(k[7:0] ^ 8'h5a);
        chk("write 0", 8'h5a ^ am ^ ah, wr_q[0]);
        chk("write 1", 8'h5a ^ am ^ ah, wr_q[1]);
        rst_dut(1'b1, 1'b1, 1'b0);
        rd_stat(8'h80);
        chk("id after reset", 8'h00, {7'h0, idv});
        $display("erase and program done");
        for (k = 0; k < 2; k = k + 1)
        begin
            rst_dut(k[0], ~k[0], 1'b0);
            repeat (8) @(posedge ref_clk);
            chk("mode off", 8'h01, {7'h0, hs & ~pma});
        end
        rst_dut(1'b1, 1'b1, 1'b1);
        d0 = $random(seed);
        d1 = $random(seed);
        send(8'hfa);
        send(8'h02);
        send(8'h00);
        send(d0 + d1);
        send(d0);
        send(d1);
        rd_stat(8'h80);
        chk("dl_ok", 8'h01, {7'h0, dl_ok});
        send(8'hfc);
        send(am);
        send(ah);
        send(8'hff);
        chk("boot out", am ^ ah, rx);
        chk("boot sel", 8'h01, {7'h0, bsel});
        $display("modes and blank done");
        stop_test;
    end
endmodule
